// File: src/psw_key.sv
//==============================================================
// key synchroniser and step generator
//==============================================================
module psw_key
   import psw_pkg::*;
#(
   parameter psw_word_t HOLD   = HOLD_CYC,
   parameter psw_word_t REPEAT = REPEAT_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic key_i,
   output logic      step_o,
   output logic      held_o
);
   typedef struct packed {
      logic      s1;
      logic      s2;
      logic      lng;
      psw_word_t cnt;
      logic      step;
   } psw_key_s;

   psw_key_s q, d;

   always_comb begin
      d      = q;
      d.s1   = key_i;
      d.s2   = q.s1;
      d.step = 1'b0;
      if (!q.s2) begin
         d.lng = 1'b0;
         d.cnt = '0;
      end else if (q.cnt == '0 && !q.lng) begin
         d.step = 1'b1;                         // R8
         d.cnt  = 32'h1;
      end else if (!q.lng && q.cnt >= HOLD - 32'h1) begin
         d.lng  = 1'b1;                         // R8
         d.step = 1'b1;
         d.cnt  = 32'h1;
      end else if (q.lng && q.cnt >= REPEAT - 32'h1) begin
         d.step = 1'b1;                         // R8
         d.cnt  = 32'h1;
      end else begin
         d.cnt = q.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign step_o = q.step;
   assign held_o = q.s2;
endmodule

// File: src/psw_pkg.sv
//==============================================================
// package
//==============================================================
// Contract
// R1 - A switching function turns on when the falling pressure reaches its lower threshold.
// R2 - A switching function turns off when the rising pressure reaches its upper threshold.
// R3 - The threshold gap stays at least 10% of the lower threshold, or 1% of full scale.
// R4 - An edit that shrinks the gap below minimum pushes the upper threshold up to restore it.
// R5 - A new gauge type pulls every stored threshold back inside that gauge's limits; the code lets an upper threshold rise past the limit to keep the gap.
// R6 - The lower threshold is bounded per gauge type, at most 1500 and mostly 1000 mbar.
// R7 - Upper threshold minimum is lower plus 10% (log) or plus 1% FS (linear), max FS linear.
// R8 - A key press under 1 s steps once; held over 1 s it steps repeatedly while held.
// R9 - A selected parameter shows its name while the key is held and at least 1.5 s.
// R10 - Fast, normal and slow filtering act on display and switching, never on analog out.
// R11 - Calibration factor scales the value: 0.10 to 9.99 log, 0.500 to 2.000 linear.
// R12 - Full scale is chosen from 0.01 mbar to 50 bar for linear gauges, automatic for log.
// R13 - With offset correction on, the stored offset is subtracted; capture within -5..110% FS.
// R14 - Offset correction touches only the displayed value, not thresholds or analog out.
// R15 - The operator disables offset correction before re-zeroing the gauge.
// R16 - Underrange suppression holds switching off about 10 s after gauge on and underrange.
// R17 - Between the thresholds each switching function keeps its previous state.
package psw_pkg;
   typedef logic [31:0] psw_word_t;
   //==============================================================
   // register map
   //==============================================================
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_CAL    = 8'h04;
   localparam logic [7:0] REG_SP1_LO = 8'h08;
   localparam logic [7:0] REG_SP1_HI = 8'h0c;
   localparam logic [7:0] REG_SP2_LO = 8'h10;
   localparam logic [7:0] REG_SP2_HI = 8'h14;
   localparam logic [7:0] REG_OFFSET = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1c;
   localparam logic [7:0] REG_DISP   = 8'h20;
   localparam int CTRL_FILT_LSB  = 0;
   localparam int CTRL_FS_LSB    = 4;
   localparam int CTRL_OFFEN_BIT = 8;
   localparam int CTRL_URSUP_BIT = 9;
   localparam int ST_GT_LSB      = 4;
   localparam int ST_SUPP_BIT    = 8;
   localparam int ST_NAME_BIT    = 9;
   //==============================================================
   // reset values (pressure lsb = 1e-4 mbar)
   //==============================================================
   localparam logic [1:0]  FILT_RST  = 2'h1;
   localparam logic [3:0]  FS_RST    = 4'h5;
   localparam logic [15:0] CAL_RST   = 16'h03e8;
   localparam psw_word_t   SP_LO_RST = 32'h000003e8;
   localparam psw_word_t   SP_HI_RST = 32'h00000514;
   //==============================================================
   // filter, calibration, scale
   //==============================================================
   localparam logic [1:0]  FILT_FAST = 2'h0;
   localparam logic [1:0]  FILT_NORM = 2'h1;
   localparam logic [1:0]  FILT_SLOW = 2'h2;
   localparam int SHIFT_FAST = 1;
   localparam int SHIFT_NORM = 3;
   localparam int SHIFT_SLOW = 5;
   localparam logic [15:0] CAL_UNITY   = 16'h03e8;
   localparam logic [15:0] CAL_LOG_MIN = 16'h0064;
   localparam logic [15:0] CAL_LOG_MAX = 16'h2706;
   localparam logic [15:0] CAL_LOG_STP = 16'h000a;
   localparam logic [15:0] CAL_LIN_MIN = 16'h01f4;
   localparam logic [15:0] CAL_LIN_MAX = 16'h07d0;
   localparam logic [15:0] CAL_LIN_STP = 16'h0001;
   localparam logic [3:0]  FS_MAX_SEL  = 4'h9;
   localparam psw_word_t   P_1500 = 32'd15000000;
   localparam psw_word_t   P_1000 = 32'd10000000;
   localparam psw_word_t   P_1EM2 = 32'd100;
   localparam psw_word_t   P_5EM4 = 32'd5;
   localparam psw_word_t   P_TINY = 32'd1;
   //==============================================================
   // timing
   //==============================================================
   localparam longint CLK_KHZ   = 200000;
   localparam longint HOLD_MS   = 1000;
   localparam longint REPEAT_MS = 100;
   localparam longint NAME_MS   = 1500;
   localparam longint SUPP_MS   = 10000;
   localparam psw_word_t HOLD_CYC   = 32'(HOLD_MS * CLK_KHZ);
   localparam psw_word_t REPEAT_CYC = 32'(REPEAT_MS * CLK_KHZ);
   localparam psw_word_t NAME_CYC   = 32'(NAME_MS * CLK_KHZ);
   localparam psw_word_t SUPP_CYC   = 32'(SUPP_MS * CLK_KHZ);
   typedef enum logic [2:0] {
      PAR_SP1_LO, PAR_SP1_HI, PAR_SP2_LO, PAR_SP2_HI, PAR_FILT, PAR_CAL, PAR_FS
   } psw_param_e;
endpackage

// File: src/psw_top.sv
//==============================================================
// pressure setpoint switching
//==============================================================
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
module psw_top
   import psw_pkg::*;
#(
   parameter psw_word_t HOLD   = HOLD_CYC,
   parameter psw_word_t REPEAT = REPEAT_CYC,
   parameter psw_word_t NAME   = NAME_CYC,
   parameter psw_word_t SUPP   = SUPP_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        key_up_i,
   input  wire logic        key_down_i,
   input  wire logic        key_sel_i,
   input  wire logic [2:0]  gauge_type_i,
   input  wire logic        gauge_on_i,
   input  wire logic        underrange_i,
   input  wire logic [31:0] pressure_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        we_i,
   input  wire logic        re_i,
   output logic      [31:0] rdata_o,
   output logic             switch_function_one_o,
   output logic             switch_function_two_o,
   output logic      [31:0] analog_o,
   output logic      [31:0] disp_value_o,
   output logic             disp_name_o,
   output logic      [2:0]  disp_param_o
);
   //==============================================================
   // helpers
   //==============================================================
   function automatic logic is_lin(input logic [2:0] gt);
      return gt == 3'h6 || gt == 3'h7;
   endfunction

   function automatic psw_word_t lim_lo(input logic [2:0] gt);
      unique case (gt)
         3'h0:    return P_5EM4;
         default: return P_TINY;
      endcase
   endfunction

   function automatic psw_word_t lim_hi(input logic [2:0] gt);
      unique case (gt)
         3'h0:       return P_1500;
         3'h1, 3'h2: return P_1EM2;
         default:    return P_1000;
      endcase
   endfunction

   function automatic psw_word_t fs_tab(input logic [3:0] s);
      unique case (s)
         4'h0:    return 32'd100;
         4'h1:    return 32'd1000;
         4'h2:    return 32'd10000;
         4'h3:    return 32'd100000;
         4'h4:    return 32'd1000000;
         4'h5:    return 32'd10000000;
         4'h6:    return 32'd20000000;
         4'h7:    return 32'd50000000;
         4'h8:    return 32'd100000000;
         default: return 32'd500000000;
      endcase
   endfunction

   function automatic psw_word_t umax(input psw_word_t a, input psw_word_t b);
      return (a > b) ? a : b;
   endfunction

   function automatic psw_word_t umin(input psw_word_t a, input psw_word_t b);
      return (a < b) ? a : b;
   endfunction

   function automatic psw_word_t bump(input psw_word_t v, input logic up);
      psw_word_t s;
      s = (v >> 4) + 32'h1;
      if (up) begin
         return (v > 32'hffffffff - s) ? 32'hffffffff : v + s;
      end
      return (v > s) ? v - s : 32'h1;
   endfunction

   // clamp one threshold pair into the limits of the gauge
   function automatic logic [63:0] fix_sp(input psw_word_t lo, input psw_word_t hi,
                                          input logic [2:0] gt, input psw_word_t fs);
      psw_word_t llo;
      psw_word_t lhi;
      psw_word_t hys;
      psw_word_t hmx;
      psw_word_t l;
      psw_word_t h;
      llo = is_lin(gt) ? umax(fs / 32'd1000, P_TINY) : lim_lo(gt);    // R6
      lhi = is_lin(gt) ? fs : lim_hi(gt);                               // R6
      l   = umin(umax(lo, llo), lhi);                                   // R5
      hys = is_lin(gt) ? fs / 32'd100 : l / 32'd10;                     // R3 R7
      hys = umax(hys, P_TINY);
      hmx = is_lin(gt) ? fs : lim_hi(gt);                               // R7
      h   = umin(hi, hmx);                                              // R5
      h   = umax(h, l + hys);                                           // R4
      return {l, h};
   endfunction

   //==============================================================
   // state
   //==============================================================
   typedef struct packed {
      logic [2:0]       gt1;
      logic [2:0]       gt2;
      logic             on1;
      logic             on2;
      logic             on3;
      logic             ur1;
      logic             ur2;
      psw_word_t        p1;
      psw_word_t        p2;
      psw_word_t        raw;
      psw_word_t        filt;
      psw_word_t        ana;
      psw_word_t        disp;
      psw_word_t        offs;
      logic             off_en;
      logic             ur_supp;
      logic [1:0]       fmode;
      logic [3:0]       fs_sel;
      logic [15:0]      cal;
      logic [1:0][31:0] lo;
      logic [1:0][31:0] hi;
      logic [1:0]       sw;
      psw_word_t        supp;
      psw_param_e       par;
      logic             name;
      psw_word_t        ncnt;
      psw_word_t        rdata;
   } psw_top_s;

   psw_top_s q, d;

   logic up_step;
   logic dn_step;
   logic sel_step;
   logic sel_held;

   psw_key #(.HOLD(HOLD), .REPEAT(REPEAT)) u_up (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .key_i  (key_up_i),
      .step_o (up_step),
      .held_o ()
   );

   psw_key #(.HOLD(HOLD), .REPEAT(REPEAT)) u_dn (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .key_i  (key_down_i),
      .step_o (dn_step),
      .held_o ()
   );

   psw_key #(.HOLD(HOLD), .REPEAT(REPEAT)) u_sel (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .key_i  (key_sel_i),
      .step_o (sel_step),
      .held_o (sel_held)
   );

   //==============================================================
   // next state
   //==============================================================
   always_comb begin
      logic             lin;
      psw_word_t        fs;
      logic [47:0]      prod;
      logic [47:0]      quo;
      logic signed [33:0] dlt;
      logic             up;
      logic             step;
      logic [15:0]      cmin;
      logic [15:0]      cmax;
      logic [15:0]      cstp;
      logic [63:0]      fx;
      int               sh;
      d      = q;
      d.gt1  = gauge_type_i;
      d.gt2  = q.gt1;
      d.on1  = gauge_on_i;
      d.on2  = q.on1;
      d.on3  = q.on2;
      d.ur1  = underrange_i;
      d.ur2  = q.ur1;
      d.p1   = pressure_i;
      d.p2   = q.p1;
      lin    = is_lin(q.gt2);
      fs     = lin ? fs_tab(q.fs_sel) : lim_hi(q.gt2);                  // R12
      cmin   = lin ? CAL_LIN_MIN : CAL_LOG_MIN;
      cmax   = lin ? CAL_LIN_MAX : CAL_LOG_MAX;
      cstp   = lin ? CAL_LIN_STP : CAL_LOG_STP;
      up     = up_step;
      step   = up_step || dn_step;
      // measurement path
      prod   = 48'(q.p2) * 48'(q.cal);                                  // R11
      quo    = prod / 48'd1000;
      d.raw  = (quo > 48'h0000ffffffff) ? 32'hffffffff : quo[31:0];
      d.ana  = q.raw;                                                   // R10 R14
      unique case (q.fmode)
         FILT_FAST: sh = SHIFT_FAST;
         FILT_SLOW: sh = SHIFT_SLOW;
         default:   sh = SHIFT_NORM;
      endcase
      dlt    = $signed({2'b00, q.raw}) - $signed({2'b00, q.filt});
      dlt    = dlt >>> sh;                                              // R10
      d.filt = 32'($signed({2'b00, q.filt}) + dlt);
      d.disp = q.filt;
      if (q.off_en) begin
         d.disp = (q.filt > q.offs) ? q.filt - q.offs : '0;             // R13 R14
      end
      // parameter selection and name display
      if (sel_step) begin
         d.par  = (q.par == PAR_FS) ? PAR_SP1_LO : psw_param_e'(q.par + 3'h1);
         d.ncnt = NAME;                                                 // R9
      end else if (q.ncnt != '0) begin
         d.ncnt = q.ncnt - 32'h1;
      end
      d.name = sel_step || sel_held || q.ncnt > 32'h1;                  // R9
      // key edits, suppressed while the name is shown
      if (step && !q.name) begin
         unique case (q.par)
            PAR_SP1_LO: d.lo[0] = bump(q.lo[0], up);
            PAR_SP1_HI: d.hi[0] = bump(q.hi[0], up);
            PAR_SP2_LO: d.lo[1] = bump(q.lo[1], up);
            PAR_SP2_HI: d.hi[1] = bump(q.hi[1], up);
            PAR_FILT: begin
               if (up && q.fmode != FILT_SLOW) begin
                  d.fmode = q.fmode + 2'h1;
               end else if (!up && q.fmode != FILT_FAST) begin
                  d.fmode = q.fmode - 2'h1;
               end
            end
            PAR_CAL:    d.cal = up ? q.cal + cstp : q.cal - cstp;      // R11
            PAR_FS: begin
               if (up && q.fs_sel != FS_MAX_SEL) begin
                  d.fs_sel = q.fs_sel + 4'h1;                           // R12
               end else if (!up && q.fs_sel != 4'h0) begin
                  d.fs_sel = q.fs_sel - 4'h1;
               end
            end
         endcase
      end
      // register writes
      if (we_i) begin
         unique case (addr_i)
            REG_CTRL: begin
               if (wdata_i[CTRL_FILT_LSB +: 2] <= FILT_SLOW) begin
                  d.fmode = wdata_i[CTRL_FILT_LSB +: 2];               // R10
               end
               if (wdata_i[CTRL_FS_LSB +: 4] <= FS_MAX_SEL) begin
                  d.fs_sel = wdata_i[CTRL_FS_LSB +: 4];                 // R12
               end
               d.off_en  = wdata_i[CTRL_OFFEN_BIT];                     // R13
               d.ur_supp = wdata_i[CTRL_URSUP_BIT];
            end
            REG_CAL:    d.cal   = wdata_i[15:0];
            REG_SP1_LO: d.lo[0] = wdata_i;
            REG_SP1_HI: d.hi[0] = wdata_i;
            REG_SP2_LO: d.lo[1] = wdata_i;
            REG_SP2_HI: d.hi[1] = wdata_i;
            REG_OFFSET: begin
               if (wdata_i[0] && 64'(q.raw) * 64'd100 <= 64'(fs) * 64'd110) begin
                  d.offs = q.raw;                                       // R13
               end
            end
            default: ;
         endcase
      end
      // limits kept continuously, so gauge changes and edits both land here
      d.cal = (d.cal < cmin) ? cmin : ((d.cal > cmax) ? cmax : d.cal);  // R11
      for (int i = 0; i < 2; i++) begin
         fx      = fix_sp(d.lo[i], d.hi[i], q.gt2, fs);                 // R3 R4 R5
         d.lo[i] = fx[63:32];
         d.hi[i] = fx[31:0];
      end
      // underrange suppression
      if (q.ur_supp && ((q.on2 && !q.on3) || q.ur2)) begin
         d.supp = SUPP;                                                 // R16
      end else if (q.supp != '0) begin
         d.supp = q.supp - 32'h1;
      end
      // switching functions
      for (int i = 0; i < 2; i++) begin
         if (q.supp != '0) begin
            d.sw[i] = 1'b0;                                             // R16
         end else if (q.filt <= q.lo[i]) begin
            d.sw[i] = 1'b1;                                             // R1
         end else if (q.filt >= q.hi[i]) begin
            d.sw[i] = 1'b0;                                             // R2
         end else begin
            d.sw[i] = q.sw[i];                                          // R17
         end
      end
      // read data
      d.rdata = '0;
      if (re_i) begin
         unique case (addr_i)
            REG_CTRL: begin
               d.rdata[CTRL_FILT_LSB +: 2] = q.fmode;
               d.rdata[CTRL_FS_LSB +: 4]   = q.fs_sel;
               d.rdata[CTRL_OFFEN_BIT]     = q.off_en;
               d.rdata[CTRL_URSUP_BIT]     = q.ur_supp;
            end
            REG_CAL:    d.rdata[15:0] = q.cal;
            REG_SP1_LO: d.rdata = q.lo[0];
            REG_SP1_HI: d.rdata = q.hi[0];
            REG_SP2_LO: d.rdata = q.lo[1];
            REG_SP2_HI: d.rdata = q.hi[1];
            REG_OFFSET: d.rdata = q.offs;
            REG_STATUS: begin
               d.rdata[1:0]             = q.sw;
               d.rdata[ST_GT_LSB +: 3]  = q.gt2;
               d.rdata[ST_SUPP_BIT]     = q.supp != '0;
               d.rdata[ST_NAME_BIT]     = q.name;
            end
            REG_DISP:   d.rdata = q.disp;
            default:    d.rdata = '0;
         endcase
      end
   end

   //==============================================================
   // registers
   //==============================================================
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q        <= '0;
         q.fmode  <= FILT_RST;
         q.fs_sel <= FS_RST;
         q.cal    <= CAL_RST;
         q.lo     <= {SP_LO_RST, SP_LO_RST};
         q.hi     <= {SP_HI_RST, SP_HI_RST};
         q.par    <= PAR_SP1_LO;
      end else begin
         q <= d;
      end
   end

   assign rdata_o               = q.rdata;
   assign switch_function_one_o = q.sw[0];
   assign switch_function_two_o = q.sw[1];
   assign analog_o              = q.ana;
   assign disp_value_o          = q.disp;
   assign disp_name_o           = q.name;
   assign disp_param_o          = q.par;
endmodule

// File: verif/pressure_setpoint_switching_tb.sv
//==============================================================
// testbench
//==============================================================
module pressure_setpoint_switching_tb import psw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] LV[6] = '{32'd50000, 32'd3000, 32'd1000, 32'd3000, 32'd5000, 32'd25000};
   localparam logic [31:0] EX [6] = '{32'h0, 32'h2, 32'h3, 32'h3, 32'h2, 32'h0};
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        kup = 1'b0, kdn = 1'b0, ksel = 1'b0, gon = 1'b1, ur = 1'b0, we = 1'b0, re = 1'b0;
   logic [2:0]  gtype = 3'h0;
   logic [7:0]  addr = 8'h0;
   logic [31:0] wdata = 32'h0, lvl = 32'h0, pres, rdata, analog, disp, v;
   logic        sw1, sw2, name;
   logic [2:0]  par;
   int          bad_count = 0, checked = 0, cyc = 0;
   psw_gauge_model u_gauge (.clk_i, .level_i(lvl), .pressure_o(pres));
   psw_top #(.HOLD(32'd20), .REPEAT(32'd5), .NAME(32'd30), .SUPP(32'd50)) u_dut (
      .clk_i, .rst_i, .key_up_i(kup), .key_down_i(kdn), .key_sel_i(ksel), .gauge_type_i(gtype),
      .gauge_on_i(gon), .underrange_i(ur), .pressure_i(pres), .addr_i(addr), .wdata_i(wdata),
      .we_i(we), .re_i(re), .rdata_o(rdata), .switch_function_one_o(sw1),
      .switch_function_two_o(sw2), .analog_o(analog), .disp_value_o(disp),
      .disp_name_o(name), .disp_param_o(par));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {we, addr, wdata} <= {1'b1, a, d};
      @(posedge clk_i);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      {re, addr} <= {1'b1, a};
      @(posedge clk_i);
      re <= 1'b0;
      @(posedge clk_i) d = rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), d, e);
   endtask
   task automatic press(input int k, input int n);
      @(posedge clk_i);
      {ksel, kdn, kup} <= 3'(1 << k);
      cy(n);
      {ksel, kdn, kup} <= 3'h0;
      cy(8);
   endtask
   task automatic lv(input logic [31:0] p, input int n);
      @(posedge clk_i);
      lvl <= p;
      cy(n);
   endtask
   task automatic t_switch;
      rc(8'h40, 32'h0);
      rc(REG_CAL, 32'h3e8);
      wr(REG_SP1_LO, 32'd2000);
      wr(REG_SP1_HI, 32'd4000);
      wr(REG_SP2_LO, 32'd10000);
      wr(REG_SP2_HI, 32'd20000);
      for (int i = 0; i < 6; i++) begin
         lv(LV[i], 300);
         chk("sw", 32'({sw2, sw1}), EX[i]);
      end
      for (int f = 0; f < 3; f++) begin
         wr(REG_CTRL, 32'h50 | 32'(f));
         rc(REG_CTRL, 32'h50 | 32'(f));
         lv(f == 1 ? 32'd8000 : 32'd3000, 8);
         chk("analog", analog, lvl);
         chk("filtered", 32'(disp !== lvl), 32'h1);
         cy(300);
      end
   endtask
   task automatic t_limits;
      wr(REG_SP1_LO, 32'd20000);
      wr(REG_SP1_HI, 32'd20500);
      rc(REG_SP1_HI, 32'd22000);
      wr(REG_SP1_LO, 32'd20000000);
      rc(REG_SP1_LO, 32'd15000000);
      @(posedge clk_i);
      gtype <= 3'h3;
      cy(10);
      rc(REG_SP1_LO, 32'd10000000);
      rd(REG_SP1_HI, v);
      chk("upper", 32'(v >= 32'd11000000), 32'h1);
      @(posedge clk_i);
      gtype <= 3'h0;
   endtask
   task automatic t_keys;
      wr(REG_SP1_LO, 32'd1600);
      press(0, 3);
      rc(REG_SP1_LO, 32'd1701);
      press(1, 3);
      rc(REG_SP1_LO, 32'd1594);
      press(0, 60);
      rd(REG_SP1_LO, v);
      chk("held", 32'(v > 32'd1800), 32'h1);
      rd(REG_SP1_HI, v);
      press(2, 3);
      chk("name", 32'(name), 32'h1);
      chk("param", 32'(par), 32'h1);
      press(0, 3);
      rc(REG_SP1_HI, v);
      @(posedge clk_i);
      ksel <= 1'b1;
      cy(60);
      chk("name", 32'(name), 32'h1);
      ksel <= 1'b0;
      cy(80);
      chk("name", 32'(name), 32'h0);
      chk("param", 32'(par), 32'h6);
   endtask
   task automatic t_offset;
      wr(REG_CTRL, 32'h150);
      wr(REG_CAL, 32'd2000);
      lv(32'd5000, 10);
      chk("analog", analog, 32'd10000);
      wr(REG_CAL, 32'd5);
      rc(REG_CAL, 32'd100);
      wr(REG_CAL, 32'd1000);
      lv(32'd5000, 50);
      wr(REG_OFFSET, 32'h1);
      rc(REG_OFFSET, 32'd5000);
      lv(32'd8000, 50);
      chk("disp", 32'(disp >= 32'd2999 && disp <= 32'd3000), 32'h1);
      chk("analog", analog, 32'd8000);
      rc(REG_SP2_LO, 32'd10000);
      lv(32'd20000000, 10);
      wr(REG_OFFSET, 32'h1);
      rc(REG_OFFSET, 32'd5000);
      wr(REG_CTRL, 32'h50);
   endtask
   task automatic t_supp;
      wr(REG_CTRL, 32'h250);
      lv(32'd500, 50);
      chk("sw", 32'({sw2, sw1}), 32'h3);
      lv(32'd500, 0);
      ur <= 1'b1;
      cy(3);
      ur <= 1'b0;
      cy(20);
      chk("sw", 32'({sw2, sw1}), 32'h0);
      cy(60);
      chk("sw", 32'({sw2, sw1}), 32'h3);
      gon <= 1'b0;
      cy(5);
      gon <= 1'b1;
      cy(20);
      chk("sw", 32'({sw2, sw1}), 32'h0);
   endtask
   task automatic results;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      cy(16);
      rst_i <= 1'b0;
      t_switch();
      t_limits();
      t_keys();
      t_offset();
      t_supp();
      results();
   end
endmodule

// File: verif/psw_checker_assertions.sv
//==============================================================
// port checker
//==============================================================
module psw_checker
   import psw_pkg::*;
#(
   parameter psw_word_t NAME = NAME_CYC
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        key_up_i,
   input wire logic [2:0]  gauge_type_i,
   input wire logic        underrange_i,
   input wire logic [31:0] pressure_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        we_i,
   input wire logic        switch_function_one_o,
   input wire logic [31:0] analog_o,
   input wire logic [31:0] disp_value_o,
   input wire logic        disp_name_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] lo_q, hi_q, n_q;
   logic        urs_q, off_q, ed_q, ok;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lo_q <= SP_LO_RST;
         hi_q <= SP_HI_RST;
         n_q  <= 32'h0;
         {urs_q, off_q, ed_q} <= 3'h0;
      end else begin
         if (we_i && addr_i == REG_SP1_LO) lo_q <= wdata_i;
         if (we_i && addr_i == REG_SP1_HI) hi_q <= wdata_i;
         if (we_i && addr_i == REG_CTRL) {urs_q, off_q} <= wdata_i[9:8];
         if (key_up_i || gauge_type_i != 3'h0) ed_q <= 1'b1;
         n_q <= disp_name_o ? n_q + 32'h1 : 32'h0;
      end
   end
   // thresholds trusted only while no up key, non-zero gauge type, offset or suppression touched them
   assign ok = !urs_q && !off_q && !ed_q;
   sequence s_low; (ok && disp_value_o <= lo_q)[*3]; endsequence
   sequence s_high; (ok && disp_value_o >= hi_q)[*3]; endsequence
   sequence s_step; $changed(pressure_i) ##1 ($stable(pressure_i) && !we_i)[*7]; endsequence
   property p_sw_on; s_low |-> ##[0:2] switch_function_one_o; endproperty
   property p_sw_off; s_high |-> ##[0:2] !switch_function_one_o; endproperty
   property p_sw_rise; ok && $rose(switch_function_one_o)
      |-> disp_value_o <= lo_q || $past(disp_value_o) <= lo_q; endproperty
   property p_sw_fall; ok && $fell(switch_function_one_o)
      |-> disp_value_o >= hi_q || $past(disp_value_o) >= hi_q; endproperty
   property p_name_rise; $rose(disp_name_o) |=> disp_name_o[*8]; endproperty
   property p_name_min; $fell(disp_name_o) |-> n_q >= NAME; endproperty
   property p_analog; s_step |=> $stable(analog_o)[*4]; endproperty
   property p_supp; $rose(underrange_i) && urs_q |-> ##5 (!switch_function_one_o)[*8]; endproperty
   a_sw_on: assert property (p_sw_on) else $error("switch not on");
   a_sw_off: assert property (p_sw_off) else $error("switch not off");
   a_sw_rise: assert property (p_sw_rise) else $error("switch rose early");
   a_sw_fall: assert property (p_sw_fall) else $error("switch fell early");
   a_name_rise: assert property (p_name_rise) else $error("name too short");
   a_name_min: assert property (p_name_min) else $error("name under minimum");
   a_analog: assert property (p_analog) else $error("analog still moving");
   a_supp: assert property (p_supp) else $error("switch not suppressed");
endmodule

bind psw_top psw_checker #(.NAME(NAME)) u_chk (
   .clk_i, .rst_i, .key_up_i, .gauge_type_i, .underrange_i, .pressure_i, .addr_i,
   .wdata_i, .we_i, .switch_function_one_o, .analog_o, .disp_value_o, .disp_name_o
);

// File: verif/psw_gauge_model.sv
//==============================================================
// gauge model
//==============================================================
module psw_gauge_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] level_i,
   output logic      [31:0] pressure_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pressure_o = 32'h0;
   // reading moves only after an edge, so it follows level_i one cycle late and stays settled while level_i holds
   always @(posedge clk_i) pressure_o <= level_i;
endmodule
